/* rtl/afc_cfg.svh */
`ifndef AFC_CFG_SVH
`define AFC_CFG_SVH
//------------------------------------------------------------
// Overview of operation
//------------------------------------------------------------

//------------------------------------------------------------
// Register map
//------------------------------------------------------------
`define AFC_OFF_CTRL      12'hf90
`define AFC_OFF_IRQ_STAT  12'hf94
`define AFC_OFF_IRQ_MASK  12'hf98
`define AFC_CTRL_RESET    8'h00
`define AFC_CTRL_WMASK    8'h9d
`define AFC_BIT_CMP_EN    0
`define AFC_BIT_RESULT    1
`define AFC_BIT_FAULT_POL 2
`define AFC_BIT_EDGE_SEL  3
`define AFC_BIT_IN_SEL    4
`define AFC_BIT_AMP_EN    7
`define AFC_IRQ_EDGE      0
`define AFC_IRQ_ANY       1
`define AFC_IRQ_W         2
`define AFC_RESP_OKAY     2'h0
`define AFC_RESP_SLVERR   2'h2
`endif

/* rtl/afc_edge.sv */
`timescale 1ns/10ps
module afc_edge (
   input  wire logic clk_i,
   input  wire logic rstn_i,
   input  wire logic level_i,
   output logic      rise_o,
   output logic      fall_o
);
   typedef struct packed {
      logic prev;
      logic valid;
   } afc_edge_s;
   afc_edge_s s_q, s_d;

   // Remember last level; no edge before first sample
   always_comb begin
      s_d       = s_q;
      s_d.prev  = level_i;
      s_d.valid = 1'b1;
   end

   // State register
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign rise_o = s_q.valid & level_i & ~s_q.prev;
   assign fall_o = s_q.valid & ~level_i & s_q.prev;
endmodule

/* rtl/afc_pkg.sv */
package afc_pkg;
   typedef enum logic [1:0] {
      AFC_IDLE = 2'b00,
      AFC_RESP = 2'b01
   } afc_bus_e;
endpackage

/* rtl/afc_sync.sv */
`timescale 1ns/10ps
module afc_sync (
   input  wire logic clk_i,
   input  wire logic rstn_i,
   input  wire logic async_i,
   output logic      sync_o
);
   typedef struct packed {
      logic meta;
      logic sync;
   } afc_sync_s;
   afc_sync_s s_q, s_d;

   // First stage read only by second stage
   always_comb begin
      s_d      = s_q;
      s_d.meta = async_i;
      s_d.sync = s_q.meta;
   end

   // State register
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign sync_o = s_q.sync;
endmodule

/* rtl/afc_top.sv */
`timescale 1ns/10ps
`include "afc_cfg.svh"
module afc_top (
   input  wire logic        REF_CLK_I,
   input  wire logic        RSTN_I,
   // AXI4-Lite slave
   input  wire logic [11:0] AWADDR_I,
   input  wire logic        AWVALID_I,
   output logic             AWREADY_O,
   input  wire logic [31:0] WDATA_I,
   input  wire logic [3:0]  WSTRB_I,
   input  wire logic        WVALID_I,
   output logic             WREADY_O,
   output logic [1:0]       BRESP_O,
   output logic             BVALID_O,
   input  wire logic        BREADY_I,
   input  wire logic [11:0] ARADDR_I,
   input  wire logic        ARVALID_I,
   output logic             ARREADY_O,
   output logic [31:0]      RDATA_O,
   output logic [1:0]       RRESP_O,
   output logic             RVALID_O,
   input  wire logic        RREADY_I,
   // Analog front end
   input  wire logic        CMP_RAW_I,
   input  wire logic        AMP_LEVEL_I,
   input  wire logic        SCHMITT_EN_I,
   output logic             CMP_ENABLE_O,
   output logic             CMP_IN_SEL_O,
   output logic             AMP_ENABLE_O,
   output logic             AMP_OUT_OE_O,
   output logic             PWM_FAULT_O,
   output logic             PORT3_AMP_BIT_O,
   output logic             PORT_B_BIT_THREE_O,
   output logic             CONV_CH3_EN_O,
   output logic             IRQ_O
);
   typedef struct packed {
      afc_pkg::afc_bus_e       wst;
      afc_pkg::afc_bus_e       rst;
      logic                    aw_ok;
      logic                    w_ok;
      logic [11:0]             awaddr;
      logic [31:0]             wdata;
      logic                    wstrb0;
      logic [1:0]              bresp;
      logic [31:0]             rdata;
      logic [1:0]              rresp;
      logic [7:0]              ctrl;
      logic [`AFC_IRQ_W-1:0]   stat;
      logic [`AFC_IRQ_W-1:0]   mask;
      logic                    fault;
      logic                    p3;
      logic                    pb3;
      logic                    irq;
      logic                    awrdy;
      logic                    wrdy;
      logic                    bvld;
      logic                    arrdy;
      logic                    rvld;
   } afc_top_s;
   afc_top_s s_q, s_d;

   logic cmp_sync;
   logic cmp_rise;
   logic cmp_fall;

   //---------------------------------------------------------
   // Comparator input path
   //---------------------------------------------------------
   // Two-flop synchroniser of the raw comparator
   afc_sync u_sync (
      .clk_i   (REF_CLK_I),
      .rstn_i  (RSTN_I),
      .async_i (CMP_RAW_I),
      .sync_o  (cmp_sync)
   );

   // Edge detector on the synchronised level
   afc_edge u_edge (
      .clk_i   (REF_CLK_I),
      .rstn_i  (RSTN_I),
      .level_i (cmp_sync),
      .rise_o  (cmp_rise),
      .fall_o  (cmp_fall)
   );

   // Mapped offset check
   function automatic logic is_mapped(input logic [11:0] a);
      is_mapped = (a == `AFC_OFF_CTRL) || (a == `AFC_OFF_IRQ_STAT)
               || (a == `AFC_OFF_IRQ_MASK);
   endfunction

   //---------------------------------------------------------
   // Next state
   //---------------------------------------------------------
   always_comb begin
      logic [`AFC_IRQ_W-1:0] ev;
      logic [`AFC_IRQ_W-1:0] clr;
      logic                  run;
      logic                  sel;
      ev  = '0;
      clr = '0;
      run = 1'b0;
      sel = 1'b0;
      s_d = s_q;

      // Write address and data taken in either order
      if (AWVALID_I && AWREADY_O) begin
         s_d.aw_ok  = 1'b1;
         s_d.awaddr = AWADDR_I;
      end
      if (WVALID_I && WREADY_O) begin
         s_d.w_ok   = 1'b1;
         s_d.wdata  = WDATA_I;
         s_d.wstrb0 = WSTRB_I[0];
      end

      // Write commit and response
      case (s_q.wst)
         afc_pkg::AFC_IDLE: begin
            if (s_q.aw_ok && s_q.w_ok) begin
               s_d.aw_ok = 1'b0;
               s_d.w_ok  = 1'b0;
               s_d.wst   = afc_pkg::AFC_RESP;
               s_d.bresp = is_mapped(s_q.awaddr) ? `AFC_RESP_OKAY
                                                 : `AFC_RESP_SLVERR;
               if (s_q.wstrb0) begin
                  if (s_q.awaddr == `AFC_OFF_CTRL) begin
                     // Reserved and status bits stay zero
                     s_d.ctrl = s_q.wdata[7:0] & `AFC_CTRL_WMASK;
                  end
                  if (s_q.awaddr == `AFC_OFF_IRQ_STAT) begin
                     clr = s_q.wdata[`AFC_IRQ_W-1:0];
                  end
                  if (s_q.awaddr == `AFC_OFF_IRQ_MASK) begin
                     s_d.mask = s_q.wdata[`AFC_IRQ_W-1:0];
                  end
               end
            end
         end
         afc_pkg::AFC_RESP: begin
            if (BREADY_I) begin
               s_d.wst = afc_pkg::AFC_IDLE;
            end
         end
         default: s_d.wst = afc_pkg::AFC_IDLE;
      endcase

      // Read path
      case (s_q.rst)
         afc_pkg::AFC_IDLE: begin
            if (ARVALID_I && ARREADY_O) begin
               s_d.rst   = afc_pkg::AFC_RESP;
               s_d.rresp = is_mapped(ARADDR_I) ? `AFC_RESP_OKAY
                                               : `AFC_RESP_SLVERR;
               s_d.rdata = '0;
               if (ARADDR_I == `AFC_OFF_CTRL) begin
                  s_d.rdata[7:0] = s_q.ctrl;
                  s_d.rdata[`AFC_BIT_RESULT] = cmp_sync;
               end
               if (ARADDR_I == `AFC_OFF_IRQ_STAT) begin
                  s_d.rdata[`AFC_IRQ_W-1:0] = s_q.stat;
               end
               if (ARADDR_I == `AFC_OFF_IRQ_MASK) begin
                  s_d.rdata[`AFC_IRQ_W-1:0] = s_q.mask;
               end
            end
         end
         afc_pkg::AFC_RESP: begin
            if (RREADY_I) begin
               s_d.rst = afc_pkg::AFC_IDLE;
            end
         end
         default: s_d.rst = afc_pkg::AFC_IDLE;
      endcase

      // Comparator events only while enabled
      run = s_q.ctrl[`AFC_BIT_CMP_EN];
      sel = s_q.ctrl[`AFC_BIT_EDGE_SEL];
      ev[`AFC_IRQ_EDGE] = run & (sel ? cmp_fall : cmp_rise);
      ev[`AFC_IRQ_ANY]  = run & (cmp_rise | cmp_fall);
      // Set wins over write-one-to-clear
      s_d.stat = (s_q.stat & ~clr) | ev;

      // Fault follows polarity select
      s_d.fault = run & (cmp_sync ^ s_q.ctrl[`AFC_BIT_FAULT_POL]);
      // Amplifier level routing
      s_d.p3  = s_q.ctrl[`AFC_BIT_AMP_EN] & SCHMITT_EN_I & AMP_LEVEL_I;
      s_d.pb3 = s_q.ctrl[`AFC_BIT_AMP_EN] & AMP_LEVEL_I;
      s_d.irq = |(s_d.stat & s_d.mask);

      // Handshake outputs registered from next state
      s_d.awrdy = (s_d.wst == afc_pkg::AFC_IDLE) & ~s_d.aw_ok;
      s_d.wrdy  = (s_d.wst == afc_pkg::AFC_IDLE) & ~s_d.w_ok;
      s_d.bvld  = (s_d.wst == afc_pkg::AFC_RESP);
      s_d.arrdy = (s_d.rst == afc_pkg::AFC_IDLE);
      s_d.rvld  = (s_d.rst == afc_pkg::AFC_RESP);
   end

   //---------------------------------------------------------
   // State register
   //---------------------------------------------------------
   always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         s_q      <= '0;
         s_q.ctrl <= `AFC_CTRL_RESET;
      end else begin
         s_q <= s_d;
      end
   end

   //---------------------------------------------------------
   // Outputs
   //---------------------------------------------------------
   assign AWREADY_O  = s_q.awrdy;
   assign WREADY_O   = s_q.wrdy;
   assign BVALID_O   = s_q.bvld;
   assign BRESP_O    = s_q.bresp;
   assign ARREADY_O  = s_q.arrdy;
   assign RVALID_O   = s_q.rvld;
   assign RDATA_O    = s_q.rdata;
   assign RRESP_O    = s_q.rresp;
   assign CMP_ENABLE_O = s_q.ctrl[`AFC_BIT_CMP_EN];
   assign CMP_IN_SEL_O = s_q.ctrl[`AFC_BIT_IN_SEL];
   assign AMP_ENABLE_O = s_q.ctrl[`AFC_BIT_AMP_EN];
   assign AMP_OUT_OE_O = s_q.ctrl[`AFC_BIT_AMP_EN];
   assign CONV_CH3_EN_O = s_q.ctrl[`AFC_BIT_AMP_EN];
   assign PWM_FAULT_O  = s_q.fault;
   assign PORT3_AMP_BIT_O = s_q.p3;
   assign PORT_B_BIT_THREE_O = s_q.pb3;
   assign IRQ_O = s_q.irq;
endmodule

/* sim/afc_top_bench.sv */
`timescale 1ns/10ps
`include "afc_cfg.svh"
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_errors++; \
   $display("mismatch t=%0t got %h exp %h", $time, (g), (e)); end end
module afc_top_bench;
   logic        clk = 1'h0, rstn = 1'h0, raw = 1'h0, lvl = 1'h0, sch = 1'h0;
   logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
   logic        arvalid = 1'h0, rready = 1'h0;
   logic [11:0] awaddr = 12'h0, araddr = 12'h0;
   logic [3:0]  wstrb = 4'hf;
   logic [31:0] wdata = 32'h0, rdata, rd_v;
   logic [1:0]  bresp, rresp, rsp;
   logic        awrdy, wrdy, bvld, arrdy, rvld, cen, csel, aen, aoe;
   logic        flt, p3, pb3, ch3, irq;
   logic [7:0]  v;
   int          n_errors = 0, cmp_count = 0, seed = 68;
   afc_top u_afc_top (.REF_CLK_I(clk), .RSTN_I(rstn), .AWADDR_I(awaddr),
      .AWVALID_I(awvalid), .AWREADY_O(awrdy), .WDATA_I(wdata),
      .WSTRB_I(wstrb), .WVALID_I(wvalid), .WREADY_O(wrdy), .BRESP_O(bresp),
      .BVALID_O(bvld), .BREADY_I(bready), .ARADDR_I(araddr),
      .ARVALID_I(arvalid), .ARREADY_O(arrdy), .RDATA_O(rdata),
      .RRESP_O(rresp), .RVALID_O(rvld), .RREADY_I(rready),
      .CMP_RAW_I(raw), .AMP_LEVEL_I(lvl), .SCHMITT_EN_I(sch),
      .CMP_ENABLE_O(cen), .CMP_IN_SEL_O(csel), .AMP_ENABLE_O(aen),
      .AMP_OUT_OE_O(aoe), .PWM_FAULT_O(flt), .PORT3_AMP_BIT_O(p3),
      .PORT_B_BIT_THREE_O(pb3), .CONV_CH3_EN_O(ch3), .IRQ_O(irq));
   // -------------------------------------------------------
   // Clock, bus tasks, expectations
   // -------------------------------------------------------
   initial forever #5 clk = ~clk;
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      int   t;
      logic aw, w, b;
      @(posedge clk);
      {awaddr, wdata} <= {a, d};
      {awvalid, wvalid, bready} <= 3'h7;
      {aw, w, b} = 3'h7;
      for (t = 0; t < 50 && b; t++) begin
         @(posedge clk);
         if (aw && awrdy) begin aw = 1'h0; awvalid <= 1'h0; end
         if (w && wrdy) begin w = 1'h0; wvalid <= 1'h0; end
         if (bvld) begin b = 1'h0; rsp = bresp; bready <= 1'h0; end
      end
      if (b) begin
         n_errors++;
         $display("mismatch t=%0t write answer missing", $time);
      end
   endtask
   task automatic rd(input logic [11:0] a);
      int   t;
      logic ar, r;
      @(posedge clk);
      araddr <= a;
      {arvalid, rready} <= 2'h3;
      {ar, r} = 2'h3;
      for (t = 0; t < 50 && r; t++) begin
         @(posedge clk);
         if (ar && arrdy) begin ar = 1'h0; arvalid <= 1'h0; end
         if (rvld) begin r = 1'h0; {rsp, rd_v} = {rresp, rdata}; end
         if (!r) rready <= 1'h0;
      end
      if (r) begin
         n_errors++;
         $display("mismatch t=%0t read answer missing", $time);
      end
   endtask
   function automatic logic [31:0] exp_ctrl(logic [7:0] c, logic s);
      return {24'h0, c & `AFC_CTRL_WMASK | {6'h0, s, 1'h0}};
   endfunction
   function automatic logic [31:0] exp_stat(logic es, logic rise);
      return {30'h0, 1'h1, rise ^ es};
   endfunction
   task automatic finish_test;
      $display("compares %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   initial begin
      repeat (30000) @(posedge clk);
      n_errors++;
      finish_test;
   end
   // -------------------------------------------------------
   // Tests
   // -------------------------------------------------------
   initial begin
      repeat (10) @(posedge clk);
      rstn <= 1'h1;
      rd(`AFC_OFF_CTRL);
      `CHK(rd_v & 32'hfffffffd, 32'h0)
      `CHK(rsp, `AFC_RESP_OKAY)
      `CHK({cen, aen, aoe, ch3}, 4'h0)
      $display("test reset done");
      repeat (12) begin
         v = 8'($random(seed));
         {raw, lvl, sch} <= {v[6], v[5], v[1]};
         wr(`AFC_OFF_CTRL, {24'h0, v & 8'h9f});
         repeat (6) @(posedge clk);
         rd(`AFC_OFF_CTRL);
         `CHK(rd_v, exp_ctrl(v, v[6]))
         `CHK({cen, csel, aen, aoe, ch3}, {v[0], v[4], {3{v[7]}}})
         `CHK({p3, pb3}, {v[7] & v[5] & v[1], v[7] & v[5]})
         `CHK(flt, v[0] & (v[6] ^ v[2]))
      end
      $display("test control done");
      for (int i = 0; i < 8; i++) begin
         wr(`AFC_OFF_IRQ_MASK, {30'h0, i[1:0]});
         rd(`AFC_OFF_IRQ_MASK);
         `CHK(rd_v, {30'h0, i[1:0]})
         wr(`AFC_OFF_CTRL, {28'h0, i[2], 3'h1});
         raw <= 1'h0;
         for (int r = 1; r >= 0; r--) begin
            repeat (8) @(posedge clk);
            wr(`AFC_OFF_IRQ_STAT, 32'h3);
            raw <= r[0];
            repeat (8) @(posedge clk);
            rd(`AFC_OFF_IRQ_STAT);
            `CHK(rd_v, exp_stat(i[2], r[0]))
            `CHK(irq, |(exp_stat(i[2], r[0]) & i[1:0]))
         end
         `CHK(cen, 1'h1)
      end
      wr(`AFC_OFF_IRQ_STAT, 32'h3);
      wr(`AFC_OFF_CTRL, 32'h0);
      raw <= 1'h1;
      repeat (8) @(posedge clk);
      rd(`AFC_OFF_IRQ_STAT);
      `CHK({irq, rd_v}, 33'h0)
      $display("test interrupt done");
      rd(12'hffc);
      `CHK({rsp, rd_v}, {`AFC_RESP_SLVERR, 32'h0})
      wr(12'hffc, 32'h1);
      `CHK(rsp, `AFC_RESP_SLVERR)
      wstrb <= 4'h0;
      wr(`AFC_OFF_CTRL, 32'h81);
      wstrb <= 4'hf;
      `CHK(rsp, `AFC_RESP_OKAY)
      rd(`AFC_OFF_CTRL);
      `CHK(rd_v & 32'hfffffffd, 32'h0)
      $display("test unmapped done");
      finish_test;
   end
endmodule

/* sim/afc_top_chk.sv */
`timescale 1ns/10ps
`include "afc_cfg.svh"
module afc_chk (
   input wire logic        REF_CLK_I,
   input wire logic        RSTN_I,
   input wire logic        AWVALID_I,
   input wire logic        AWREADY_O,
   input wire logic        WVALID_I,
   input wire logic        WREADY_O,
   input wire logic [1:0]  BRESP_O,
   input wire logic        BVALID_O,
   input wire logic        BREADY_I,
   input wire logic [11:0] ARADDR_I,
   input wire logic        ARVALID_I,
   input wire logic        ARREADY_O,
   input wire logic [31:0] RDATA_O,
   input wire logic        RVALID_O,
   input wire logic        RREADY_I,
   input wire logic        AMP_LEVEL_I,
   input wire logic        SCHMITT_EN_I,
   input wire logic        CMP_ENABLE_O,
   input wire logic        AMP_ENABLE_O,
   input wire logic        AMP_OUT_OE_O,
   input wire logic        PWM_FAULT_O,
   input wire logic        PORT3_AMP_BIT_O,
   input wire logic        PORT_B_BIT_THREE_O,
   input wire logic        CONV_CH3_EN_O
);
   // -------------------------------------------------------
   // Handshake steps
   // -------------------------------------------------------
   default clocking cb @(posedge REF_CLK_I); endclocking
   default disable iff (!RSTN_I);
   sequence s_ar_take; ARVALID_I && ARREADY_O; endsequence
   sequence s_wr_take; AWVALID_I && AWREADY_O && WVALID_I && WREADY_O;
   endsequence
   // -------------------------------------------------------
   // Checks
   // -------------------------------------------------------
   a_amp_hiz: assert property (AMP_OUT_OE_O == AMP_ENABLE_O)
      else $error("amplifier pin drive differs from enable");
   a_conv_feed: assert property (CONV_CH3_EN_O == AMP_ENABLE_O)
      else $error("converter feed differs from enable");
   a_port3_gate: assert property (PORT3_AMP_BIT_O ==
      $past(AMP_ENABLE_O && SCHMITT_EN_I && AMP_LEVEL_I))
      else $error("port 3 amplifier bit wrong");
   a_portb_gate: assert property (PORT_B_BIT_THREE_O ==
      $past(AMP_ENABLE_O && AMP_LEVEL_I))
      else $error("port B bit three wrong");
   a_fault_gate: assert property (PWM_FAULT_O |->
      CMP_ENABLE_O || $past(CMP_ENABLE_O))
      else $error("fault active with comparator off");
   a_b_hold: assert property (BVALID_O && !BREADY_I |=>
      BVALID_O && $stable(BRESP_O)) else $error("write response dropped");
   a_r_hold: assert property (RVALID_O && !RREADY_I |=>
      RVALID_O && $stable(RDATA_O)) else $error("read data dropped");
   a_read_lat: assert property (s_ar_take |=> RVALID_O)
      else $error("read answer late");
   a_write_lat: assert property (s_wr_take |-> ##[1:2] BVALID_O)
      else $error("write answer late");
   a_ctrl_rsvd: assert property ((s_ar_take and
      (ARADDR_I == `AFC_OFF_CTRL)) ##1 RVALID_O |->
      RDATA_O[6:5] == 2'h0 && RDATA_O[31:8] == 24'h0)
      else $error("reserved control bits not zero");
endmodule
bind afc_top afc_chk u_afc_chk (.*);
